// file: isl_pkg.sv
// constants and types shared by the two-wire slave transaction engine
package isl_pkg;

    // =========================================================
    // mode field encoding
    localparam logic [1:0] MODE_MS_7 = 2'h0;
    localparam logic [1:0] MODE_MS_10 = 2'h1;
    localparam logic [1:0] MODE_SLV_7 = 2'h2;
    localparam logic [1:0] MODE_SLV_10 = 2'h3;
    localparam int MODE_TEN_BIT = 0; // this bit selects 10-bit width

    // =========================================================
    // address patterns
    localparam logic [4:0] TEN_PREFIX = 5'h1e;
    localparam logic [7:0] GEN_CALL_BYTE = 8'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // =========================================================
    // reset values
    localparam logic TX_EMPTY_RST = 1'b1;
    localparam logic [7:0] DATA_RST = 8'h00;

    // =========================================================
    // event toggles from link to system domain
    localparam int EV_MATCH = 0;
    localparam int EV_RX = 1;
    localparam int EV_TAKE = 2;
    localparam int EV_NACK = 3;
    localparam int EV_STOP = 4;
    localparam int EV_NUM = 5;

    // config word width carried to the link domain
    localparam int CFG_W = 16;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR2, ST_RX, ST_ACK_A2, ST_ACK_RX,
        ST_ACK_TX, ST_TX_LOAD, ST_TX, ST_TX_ACK
    } isl_state_t;

endpackage : isl_pkg

// file: isl_slave_engine.sv
// two-wire slave engine: link-side bit engine and software-side flags
`timescale 1ns/10ps
module isl_slave_engine (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic link_clk_i,
    input wire logic [1:0] mode_i,
    input wire logic [1:0] own_addr_hi_i,
    input wire logic [7:0] own_address_i,
    input wire logic controller_on_bit_i,
    input wire logic refuse_ack_i,
    input wire logic general_call_accept_i,
    input wire logic transmit_irq_enable_i,
    input wire logic flush_i,
    input wire logic status_rd_i,
    input wire logic data_rd_i,
    input wire logic data_wr_i,
    input wire logic [7:0] data_wdata_i,
    output logic [7:0] data_rdata_o,
    output logic addr_match_flag_o,
    output logic general_call_flag_o,
    output logic master_reads_flag_o,
    output logic rx_full_flag_o,
    output logic tx_empty_flag_o,
    output logic nack_seen_flag_o,
    output logic stop_restart_flag_o,
    output logic irq_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);

    // =========================================================
    // system domain state
    logic addr_match, gc_flag, rd_flag, rx_full, tx_empty;
    logic nack_seen, stop_flag, sam_ack, irq;
    logic [7:0] tx_data, rx_data;
    logic next_addr_match, next_gc_flag, next_rd_flag, next_rx_full;
    logic next_tx_empty, next_nack_seen, next_stop_flag, next_sam_ack;
    logic next_irq;
    logic [7:0] next_tx_data, next_rx_data;
    logic [isl_pkg::EV_NUM-1:0] ev_s1, ev_s2, ev_s3, ev_hit;

    // =========================================================
    // link domain state
    isl_pkg::isl_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] sh, next_sh, rx_hold, next_rx_hold;
    logic rd_hold, next_rd_hold, gc_hold, next_gc_hold;
    logic ten_hit, next_ten_hit, addressed, next_addressed;
    logic sda_dr, next_sda_dr, scl_dr, next_scl_dr;
    logic [isl_pkg::EV_NUM-1:0] ev_tgl, next_ev_tgl;
    logic [2:0] scl_s, sda_s;
    logic scl_q, sda_q, scl_p, sda_p, next_scl_q, next_sda_q;
    logic [isl_pkg::CFG_W-1:0] cfg_s1, cfg_s2, cfg_word;

    // config as seen by the link; all quasi-static except two bits
    logic tx_full_s, ack_s, on_s, refuse_s, gcen_s, ten_s;
    logic [9:0] own_s;
    assign cfg_word = {tx_empty, sam_ack, controller_on_bit_i,
                       refuse_ack_i, general_call_accept_i,
                       mode_i[isl_pkg::MODE_TEN_BIT], own_addr_hi_i,
                       own_address_i};
    assign tx_full_s = !cfg_s2[15];
    assign ack_s = cfg_s2[14];
    assign on_s = cfg_s2[13];
    assign refuse_s = cfg_s2[12];
    assign gcen_s = cfg_s2[11];
    assign ten_s = cfg_s2[10];
    assign own_s = cfg_s2[9:0];

    // =========================================================
    // system side: event edges from link toggles
    assign ev_hit = ev_s2 ^ ev_s3;

    // flag updates; every hardware set wins over a same-cycle clear
    always_comb begin
        next_addr_match = addr_match;
        next_gc_flag = gc_flag;
        next_rd_flag = rd_flag;
        next_rx_full = rx_full;
        next_tx_empty = tx_empty;
        next_nack_seen = nack_seen;
        next_stop_flag = stop_flag;
        next_sam_ack = sam_ack;
        next_tx_data = tx_data;
        next_rx_data = rx_data;
        if (status_rd_i) begin
            next_addr_match = 1'b0;
            next_stop_flag = 1'b0;
            next_nack_seen = 1'b0;
            // servicing the match lets the link release its stretch
            next_sam_ack = ev_s2[isl_pkg::EV_MATCH];
        end
        if (data_rd_i) begin
            next_rx_full = 1'b0;
        end
        // writes while a byte is still pending are dropped, so the
        // link can read tx_data without a second handshake
        if (data_wr_i && tx_empty) begin
            next_tx_data = data_wdata_i;
            next_tx_empty = 1'b0;
        end
        if (flush_i) begin
            next_tx_empty = 1'b1;
        end
        if (ev_hit[isl_pkg::EV_MATCH]) begin
            next_addr_match = 1'b1;
            next_rd_flag = rd_hold;
            next_gc_flag = gc_hold;
        end
        if (ev_hit[isl_pkg::EV_RX]) begin
            next_rx_data = rx_hold;
            next_rx_full = 1'b1;
        end
        if (ev_hit[isl_pkg::EV_TAKE]) begin
            next_tx_empty = 1'b1;
        end
        if (ev_hit[isl_pkg::EV_NACK]) begin
            next_nack_seen = 1'b1;
        end
        if (ev_hit[isl_pkg::EV_STOP]) begin
            next_stop_flag = 1'b1;
        end
        // tx interrupt only counts while software enables it
        next_irq = next_addr_match | next_rx_full | next_nack_seen |
                   next_stop_flag |
                   (next_tx_empty & transmit_irq_enable_i);
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_match <= 1'b0;
            gc_flag <= 1'b0;
            rd_flag <= 1'b0;
            rx_full <= 1'b0;
            tx_empty <= isl_pkg::TX_EMPTY_RST;
            nack_seen <= 1'b0;
            stop_flag <= 1'b0;
            sam_ack <= 1'b0;
            irq <= 1'b0;
            tx_data <= isl_pkg::DATA_RST;
            rx_data <= isl_pkg::DATA_RST;
            ev_s1 <= '0;
            ev_s2 <= '0;
            ev_s3 <= '0;
        end else begin
            addr_match <= next_addr_match;
            gc_flag <= next_gc_flag;
            rd_flag <= next_rd_flag;
            rx_full <= next_rx_full;
            tx_empty <= next_tx_empty;
            nack_seen <= next_nack_seen;
            stop_flag <= next_stop_flag;
            sam_ack <= next_sam_ack;
            irq <= next_irq;
            tx_data <= next_tx_data;
            rx_data <= next_rx_data;
            ev_s1 <= ev_tgl; // toggle crossing, first stage
            ev_s2 <= ev_s1;
            ev_s3 <= ev_s2;
        end
    end

    assign data_rdata_o = rx_data;
    assign addr_match_flag_o = addr_match;
    assign general_call_flag_o = gc_flag;
    assign master_reads_flag_o = rd_flag;
    assign rx_full_flag_o = rx_full;
    assign tx_empty_flag_o = tx_empty;
    assign nack_seen_flag_o = nack_seen;
    assign stop_restart_flag_o = stop_flag;
    assign irq_o = irq;

    // =========================================================
    // link side: pin filter, bus conditions, byte engine
    logic scl_rise, scl_fall, bus_start, bus_stop, pend;
    logic m7, gc_ok, tenp;
    assign scl_rise = scl_q & !scl_p;
    assign scl_fall = !scl_q & scl_p;
    assign bus_start = scl_q & scl_p & sda_p & !sda_q;
    assign bus_stop = scl_q & scl_p & !sda_p & sda_q;
    assign pend = ev_tgl[isl_pkg::EV_MATCH] != ack_s;
    // address decode on the byte just shifted in
    assign m7 = !ten_s && (sh[7:1] == own_s[6:0]);
    assign gc_ok = gcen_s && (sh == isl_pkg::GEN_CALL_BYTE);
    assign tenp = ten_s && (sh[7:3] == isl_pkg::TEN_PREFIX) &&
                  (sh[2:1] == own_s[9:8]);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_sh = sh;
        next_rx_hold = rx_hold;
        next_rd_hold = rd_hold;
        next_gc_hold = gc_hold;
        next_ten_hit = ten_hit;
        next_addressed = addressed;
        next_sda_dr = sda_dr;
        next_scl_dr = scl_dr;
        next_ev_tgl = ev_tgl;
        // a pin level counts once the second and third stages agree
        next_scl_q = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_q;
        next_sda_q = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_q;
        if (bus_start || bus_stop) begin
            if (addressed) begin
                next_ev_tgl[isl_pkg::EV_STOP] = !ev_tgl[isl_pkg::EV_STOP];
            end
            next_addressed = 1'b0;
            next_sda_dr = 1'b0;
            next_scl_dr = 1'b0;
            next_cnt = '0;
            next_state = bus_start ? isl_pkg::ST_ADDR : isl_pkg::ST_IDLE;
            // 10-bit first-byte hit survives a restart only
            if (bus_stop) begin
                next_ten_hit = 1'b0;
            end
        end else begin
            unique case (state)
                isl_pkg::ST_IDLE: begin
                end
                isl_pkg::ST_ADDR, isl_pkg::ST_ADDR2, isl_pkg::ST_RX: begin
                    if (scl_rise) begin
                        next_sh = {sh[6:0], sda_q};
                        next_cnt = cnt + 4'h1;
                    end
                    if (scl_fall && cnt == isl_pkg::BITS_PER_BYTE) begin
                        next_cnt = '0;
                        next_state = isl_pkg::ST_IDLE;
                        if (!on_s) begin
                            next_state = isl_pkg::ST_IDLE;
                        end else if (state == isl_pkg::ST_RX) begin
                            next_rx_hold = sh;
                            next_ev_tgl[isl_pkg::EV_RX] =
                                !ev_tgl[isl_pkg::EV_RX];
                            next_sda_dr = !refuse_s;
                            next_state = isl_pkg::ST_ACK_RX;
                        end else if (state == isl_pkg::ST_ADDR2) begin
                            if (sh == own_s[7:0]) begin
                                next_rd_hold = 1'b0;
                                next_gc_hold = 1'b0;
                                next_ev_tgl[isl_pkg::EV_MATCH] =
                                    !ev_tgl[isl_pkg::EV_MATCH];
                                next_addressed = 1'b1;
                                next_sda_dr = 1'b1;
                                next_state = isl_pkg::ST_ACK_RX;
                            end else begin
                                next_ten_hit = 1'b0;
                            end
                        end else if ((m7 || gc_ok) && !(gc_ok && sh[0]))
                        begin // start byte is refused unless 7-bit mode and own_s[6:0] is zero
                            next_rd_hold = sh[0];
                            next_gc_hold = gc_ok;
                            next_ev_tgl[isl_pkg::EV_MATCH] =
                                !ev_tgl[isl_pkg::EV_MATCH];
                            next_addressed = 1'b1;
                            next_sda_dr = 1'b1;
                            next_state = sh[0] ? isl_pkg::ST_ACK_TX :
                                                 isl_pkg::ST_ACK_RX;
                        end else if (tenp && !sh[0]) begin
                            next_ten_hit = 1'b1;
                            next_sda_dr = 1'b1;
                            next_state = isl_pkg::ST_ACK_A2;
                        end else if (tenp && ten_hit) begin
                            // restart read after a full 10-bit match
                            next_rd_hold = 1'b1;
                            next_gc_hold = 1'b0;
                            next_ev_tgl[isl_pkg::EV_MATCH] =
                                !ev_tgl[isl_pkg::EV_MATCH];
                            next_addressed = 1'b1;
                            next_sda_dr = 1'b1;
                            next_state = isl_pkg::ST_ACK_TX;
                        end
                    end
                end
                isl_pkg::ST_ACK_A2: begin
                    if (scl_fall) begin
                        next_sda_dr = 1'b0;
                        next_state = isl_pkg::ST_ADDR2;
                    end
                end
                isl_pkg::ST_ACK_RX: begin
                    // hold clock low while the match is unserviced
                    if (scl_fall || scl_dr) begin
                        next_sda_dr = 1'b0;
                        next_scl_dr = pend;
                        if (!pend) begin
                            next_state = isl_pkg::ST_RX;
                        end
                    end
                end
                isl_pkg::ST_ACK_TX: begin
                    if (scl_fall) begin
                        next_sda_dr = 1'b0;
                        next_state = isl_pkg::ST_TX_LOAD;
                    end
                end
                isl_pkg::ST_TX_LOAD: begin
                    // clock stays low until software supplies a byte
                    next_scl_dr = !tx_full_s;
                    if (tx_full_s) begin
                        next_sh = tx_data;
                        next_sda_dr = !tx_data[7];
                        next_cnt = '0;
                        next_state = isl_pkg::ST_TX;
                    end
                end
                isl_pkg::ST_TX: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 4'h1;
                        if (cnt == '0) begin
                            next_ev_tgl[isl_pkg::EV_TAKE] =
                                !ev_tgl[isl_pkg::EV_TAKE];
                        end
                    end
                    if (scl_fall) begin
                        if (cnt == isl_pkg::BITS_PER_BYTE) begin
                            next_sda_dr = 1'b0;
                            next_state = isl_pkg::ST_TX_ACK;
                        end else begin
                            next_sh = {sh[6:0], 1'b0};
                            next_sda_dr = !sh[6];
                        end
                    end
                end
                isl_pkg::ST_TX_ACK: begin
                    if (scl_rise && sda_q) begin
                        next_ev_tgl[isl_pkg::EV_NACK] =
                            !ev_tgl[isl_pkg::EV_NACK];
                        next_state = isl_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        next_state = isl_pkg::ST_TX_LOAD;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge link_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= isl_pkg::ST_IDLE;
            cnt <= '0;
            sh <= isl_pkg::DATA_RST;
            rx_hold <= isl_pkg::DATA_RST;
            rd_hold <= 1'b0;
            gc_hold <= 1'b0;
            ten_hit <= 1'b0;
            addressed <= 1'b0;
            sda_dr <= 1'b0;
            scl_dr <= 1'b0;
            ev_tgl <= '0;
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            cfg_s1 <= '0;
            cfg_s2 <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            sh <= next_sh;
            rx_hold <= next_rx_hold;
            rd_hold <= next_rd_hold;
            gc_hold <= next_gc_hold;
            ten_hit <= next_ten_hit;
            addressed <= next_addressed;
            sda_dr <= next_sda_dr;
            scl_dr <= next_scl_dr;
            ev_tgl <= next_ev_tgl;
            scl_s <= {scl_s[1:0], scl_i};
            sda_s <= {sda_s[1:0], sda_i};
            scl_q <= next_scl_q;
            sda_q <= next_sda_q;
            scl_p <= scl_q;
            sda_p <= sda_q;
            cfg_s1 <= cfg_word;
            cfg_s2 <= cfg_s1;
        end
    end

    // open-drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_dr;
    assign sda_oe_o = sda_dr;

endmodule : isl_slave_engine

// file: isl_engine_props.sv
// checker for the slave engine's software-side flags and sda pin enable
`timescale 1ns/10ps
module isl_engine_props (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic controller_on_bit_i,
    input wire logic transmit_irq_enable_i,
    input wire logic flush_i,
    input wire logic status_rd_i,
    input wire logic data_rd_i,
    input wire logic data_wr_i,
    input wire logic addr_match_flag_o,
    input wire logic master_reads_flag_o,
    input wire logic rx_full_flag_o,
    input wire logic tx_empty_flag_o,
    input wire logic nack_seen_flag_o,
    input wire logic stop_restart_flag_o,
    input wire logic irq_o,
    input wire logic sda_oe_o
);
    // =========================================================
    // one domain, so clock and disable are given once
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // controller off long enough to settle
    sequence s_off4;
        !controller_on_bit_i [*4];
    endsequence
    property p_match_clr; status_rd_i |=> !addr_match_flag_o; endproperty
    property p_stop_clr; status_rd_i |=> !stop_restart_flag_o; endproperty
    property p_rx_clr; data_rd_i |=> !rx_full_flag_o; endproperty
    property p_txe_clr;
        data_wr_i && tx_empty_flag_o |=> !tx_empty_flag_o;
    endproperty
    property p_flush; flush_i |=> tx_empty_flag_o; endproperty
    property p_rx_dir; $rose(rx_full_flag_o) |-> !master_reads_flag_o; endproperty
    property p_nack_dir;
        $rose(nack_seen_flag_o) |-> master_reads_flag_o;
    endproperty
    property p_txe_dir;
        $rose(tx_empty_flag_o) |-> master_reads_flag_o || $past(flush_i);
    endproperty
    // irq ors the flags; tx_empty only when enabled
    property p_irq;
        $stable(transmit_irq_enable_i) |-> irq_o == (addr_match_flag_o |
            rx_full_flag_o | nack_seen_flag_o | stop_restart_flag_o |
            (tx_empty_flag_o & transmit_irq_enable_i));
    endproperty
    property p_off; s_off4 |-> !sda_oe_o; endproperty
    a_match_clr: assert property (p_match_clr)
        else $error("match kept");
    a_stop_clr: assert property (p_stop_clr)
        else $error("stop kept");
    a_rx_clr: assert property (p_rx_clr)
        else $error("rx full kept");
    a_txe_clr: assert property (p_txe_clr)
        else $error("tx empty kept");
    a_flush: assert property (p_flush)
        else $error("flush ignored");
    a_rx_dir: assert property (p_rx_dir)
        else $error("rx in read");
    a_nack_dir: assert property (p_nack_dir)
        else $error("nack in write");
    a_txe_dir: assert property (p_txe_dir)
        else $error("stray tx empty");
    a_irq: assert property (p_irq)
        else $error("irq mismatch");
    a_off: assert property (p_off)
        else $error("sda while off");
endmodule : isl_engine_props

bind isl_slave_engine isl_engine_props u_isl_engine_props (.*);

// file: isl_master_model.sv
// behavioural two-wire bus master driving the slave engine's pins
`timescale 1ns/10ps
module isl_master_model (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_dn_o,
    output logic sda_dn_o
);
    // =========================================================
    // half bit time; slow against the link filter and flag crossing
    localparam int T = 250;
    initial begin
        scl_dn_o = 1'b0;
        sda_dn_o = 1'b0;
    end
    // release scl and wait out any stretch the slave applies
    task automatic scl_high();
        scl_dn_o = 1'b0;
        wait (scl_i === 1'b1);
        #T;
    endtask : scl_high
    // start or repeated start; the #20 keeps sda off the scl fall
    task automatic start();
        #20;
        sda_dn_o = 1'b0;
        #T;
        scl_high();
        sda_dn_o = 1'b1;
        #T;
        scl_dn_o = 1'b1;
    endtask : start
    task automatic stop();
        #20;
        sda_dn_o = 1'b1;
        #T;
        scl_high();
        sda_dn_o = 1'b0;
        #T;
    endtask : stop
    // eight bits msb first and the ninth; released bits read the slave
    task automatic xfer(input logic [7:0] d, input logic a_in,
                        output logic [7:0] q, output logic a_out);
        logic [8:0] w;
        w = {d, a_in};
        for (int i = 8; i >= 0; i--) begin
            #20;
            sda_dn_o = !w[i];
            #T;
            scl_high();
            if (i > 0)
                q[i-1] = sda_i;
            else
                a_out = sda_i;
            scl_dn_o = 1'b1;
        end
    endtask : xfer
endmodule : isl_master_model

// file: isl_slave_engine_bench.sv
// self-checking bench for the two-wire slave engine
`timescale 1ns/10ps
module isl_slave_engine_bench;
    logic sys_clk_i = 0, link_clk_i = 0, nrst_i = 0, m_scl, m_sda;
    logic [1:0] mode_i = isl_pkg::MODE_SLV_7, own_addr_hi_i = 0;
    logic [7:0] own_address_i = 0, data_wdata_i = 0, data_rdata_o, q, d0, d1;
    logic controller_on_bit_i = 0, refuse_ack_i = 0, flush_i = 0;
    logic general_call_accept_i = 0, transmit_irq_enable_i = 0;
    logic status_rd_i = 0, data_rd_i = 0, data_wr_i = 0, a, ten;
    logic am, gc, mr, rf, te, ns, sr, irq_o, scl_oe_o, sda_oe_o;
    logic seen_rd, seen_gc;
    logic [3:0] n_match, n_stop, n_nack;
    logic [7:0] txq[$], rxq[$];
    int fail_count = 0, n_tests = 0, cyc = 0, gap = 0;
    // open-drain wires with pull-ups
    wire scl = !(m_scl | scl_oe_o);
    wire sda = !(m_sda | sda_oe_o);
    isl_slave_engine u_isl_slave_engine (.sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i), .link_clk_i(link_clk_i), .mode_i(mode_i),
        .own_addr_hi_i(own_addr_hi_i), .own_address_i(own_address_i),
        .controller_on_bit_i(controller_on_bit_i),
        .refuse_ack_i(refuse_ack_i), .transmit_irq_enable_i(transmit_irq_enable_i),
        .general_call_accept_i(general_call_accept_i), .flush_i(flush_i),
        .status_rd_i(status_rd_i), .data_rd_i(data_rd_i),
        .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i),
        .data_rdata_o(data_rdata_o), .addr_match_flag_o(am),
        .general_call_flag_o(gc), .master_reads_flag_o(mr),
        .rx_full_flag_o(rf), .tx_empty_flag_o(te), .nack_seen_flag_o(ns),
        .stop_restart_flag_o(sr), .irq_o(irq_o), .scl_i(scl), .scl_o(),
        .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe_o));
    isl_master_model u_isl_master_model (.scl_i(scl), .sda_i(sda),
        .scl_dn_o(m_scl), .sda_dn_o(m_sda));
    // =========================================================
    // clocks, unrelated in phase
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    initial forever #3 link_clk_i = ~link_clk_i;
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // a hang counts as a mismatch
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [7:0] first_byte(logic t, logic [7:0] ad,
                                              logic [1:0] hi, logic rd);
        return t ? {isl_pkg::TEN_PREFIX, hi, rd} : {ad[6:0], rd};
    endfunction : first_byte
    // let flag events cross
    task automatic settle();
        repeat (40) @(posedge sys_clk_i);
        #3;
    endtask : settle
    task automatic clear_counts();
        n_match = 0;
        n_stop = 0;
        n_nack = 0;
        rxq.delete();
    endtask : clear_counts
    // software model: services flags; a random gap forces scl stretch
    initial forever begin
        @(posedge sys_clk_i);
        #1;
        {status_rd_i, data_rd_i, data_wr_i, flush_i} = 4'h0;
        if (am === 1'b1) begin
            seen_rd = mr;
            seen_gc = gc;
            n_match++;
        end
        if (sr === 1'b1)
            n_stop++;
        if (ns === 1'b1) begin
            n_nack++;
            flush_i = 1'b1;
            transmit_irq_enable_i = 1'b0;
        end
        status_rd_i = (am | sr | ns) === 1'b1;
        if (rf === 1'b1) begin
            rxq.push_back(data_rdata_o);
            data_rd_i = 1'b1;
        end
        if ((te & mr) === 1'b1 && txq.size() > 0) begin
            if (gap > 0)
                gap--;
            else begin
                data_wr_i = 1'b1;
                data_wdata_i = txq.pop_front();
                gap = $urandom_range(400, 200);
            end
        end
    end
    initial begin
        void'($urandom(72053));
        repeat (6) @(posedge sys_clk_i);
        #1 nrst_i = 1'b1;
        check({irq_o, am, gc, mr, rf, ns, sr, te}, 8'h01);
        check(data_rdata_o, isl_pkg::DATA_RST);
        own_address_i = 8'($urandom) | 8'h10;
        u_isl_master_model.start();
        u_isl_master_model.xfer(first_byte(0, own_address_i, 0, 0), 1, q, a);
        check(a, 1);
        u_isl_master_model.stop();
        controller_on_bit_i = 1'b1;
        for (int m = 0; m < 4; m++) begin
            mode_i = 2'(m);
            ten = mode_i[isl_pkg::MODE_TEN_BIT];
            own_address_i = 8'($urandom) | 8'h10;
            own_addr_hi_i = 2'($urandom);
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            settle();
            clear_counts();
            // a near-miss address and its stop are ignored
            u_isl_master_model.start();
            u_isl_master_model.xfer(first_byte(ten, own_address_i ^ 8'h01,
                own_addr_hi_i ^ 2'h1, 0), 1, q, a);
            check(a, 1);
            u_isl_master_model.stop();
            u_isl_master_model.start();
            u_isl_master_model.xfer(first_byte(ten, own_address_i,
                own_addr_hi_i, 0), 1, q, a);
            check(a, 0);
            if (ten) begin
                u_isl_master_model.xfer(own_address_i, 1, q, a);
                check(a, 0);
            end
            u_isl_master_model.xfer(d0, 1, q, a);
            check(a, 0);
            refuse_ack_i = 1'b1;
            u_isl_master_model.xfer(d1, 1, q, a);
            check(a, 1);
            refuse_ack_i = 1'b0;
            u_isl_master_model.stop();
            settle();
            check(seen_rd, 0);
            check({n_match, n_stop}, 8'h11);
            check(8'(rxq.size()), 8'h02);
            if (rxq.size() == 2) begin
                check(rxq[0], d0);
                check(rxq[1], d1);
            end
        end
        mode_i = isl_pkg::MODE_SLV_7;
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        settle();
        clear_counts();
        txq = '{d0, d1};
        gap = 40;
        transmit_irq_enable_i = 1'b1;
        u_isl_master_model.start();
        u_isl_master_model.xfer(first_byte(0, own_address_i, 0, 1), 1, q, a);
        check(a, 0);
        u_isl_master_model.xfer(8'hff, 0, q, a);
        check(q, d0);
        u_isl_master_model.xfer(8'hff, 1, q, a);
        check(q, d1);
        u_isl_master_model.stop();
        settle();
        check(seen_rd, 1);
        check({n_nack, n_stop}, 8'h11);
        check(te, 1);
        general_call_accept_i = 1'b1;
        clear_counts();
        u_isl_master_model.start();
        u_isl_master_model.xfer(8'h01, 1, q, a);
        check(a, 1); // start byte refused
        u_isl_master_model.start();
        u_isl_master_model.xfer(isl_pkg::GEN_CALL_BYTE, 1, q, a);
        check(a, 0);
        u_isl_master_model.stop();
        settle();
        check({seen_gc, n_match}, 8'h11);
        finish_test();
    end
endmodule : isl_slave_engine_bench
